// >>> hdl/bfd_defs.svh
// address map and constant values of the burst fifo data port
`ifndef BFD_DEFS_SVH
`define BFD_DEFS_SVH
`define BFD_CHAN_STRIDE 12'h200
`define BFD_LEGACY_OFF 9'h000
`define BFD_DATA_OFF 9'h100
`define BFD_DATA_END 9'h13f
`define BFD_STAT_OFF 9'h180
`define BFD_STAT_END 9'h1ff
`define BFD_EMPTY_BYTE 8'h00
`define BFD_BE_LEGACY 4'h1
`define BFD_BE_LOW_HALF 4'h3
`define BFD_BE_HIGH_HALF 4'hc
`define BFD_BE_FULL 4'hf
`endif

// >>> hdl/bfd_pkg.sv
// types shared by the burst fifo data port
package bfd_pkg;
  typedef enum logic [1:0] {
    WIN_NONE = 2'b00,
    WIN_LEGACY = 2'b01,
    WIN_DATA = 2'b10,
    WIN_STAT = 2'b11
  } bfd_win_t;
  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_TAKE = 2'b01,
    RD_WAIT = 2'b10
  } bfd_rd_state_t;
endpackage : bfd_pkg

// >>> hdl/bfd_word_fifo.sv
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/10ps
module bfd_word_fifo #(
  parameter int WIDTH = 39,
  parameter int DEPTH = 4
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  // sizes the pointers cannot serve stop elaboration
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("fifo depth must be a power of two, at least 2");
  end
  if (WIDTH < 1)
  begin : g_bad_width
    $error("fifo width must be positive");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  // honest flags straight from the occupancy count
  assign in_ready = (cnt_r < (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rd_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // pointer and count update; a push while full is impossible
  always_comb
  begin
    mem_nxt = mem_r;
    wr_nxt = wr_r;
    rd_nxt = rd_r;
    cnt_nxt = cnt_r;
    if (push)
    begin
      mem_nxt[wr_r] = in_data;
      wr_nxt = wr_r + 1'b1;
    end
    if (pop)
      rd_nxt = rd_r + 1'b1;
    if (push && !pop)
      cnt_nxt = cnt_r + 1'b1;
    else if (pop && !push)
      cnt_nxt = cnt_r - 1'b1;
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // storage needs no reset; empty entries are never presented
  always_ff @(posedge clock)
  begin
    mem_r <= mem_nxt;
  end
endmodule : bfd_word_fifo

// >>> hdl/bfd_data_port.sv
// burst data port between the bus access port and the channel fifos
`timescale 1ns/10ps
`include "bfd_defs.svh"

// Contract
// - burst reads and writes decode anywhere in the mapped windows; writes to the status window are refused with an error.
// - per-channel data window at 0x100 + 0x200*n, read rx, write tx.
// - plain rx read puts oldest byte in lane 0, then lanes 1..3.
// - data window write queues lane 0 first, then lanes 1, 2, 3.
// - status window at 0x180 + 0x200*n, status low byte, data high.
// - status window spans 32 words so a full fifo drains in one burst.
// - data window takes 8, 16, 24 or 32 bit accesses, byte per lane.
// - bursts of up to 64 data bytes to or from a channel fifo.
// - legacy holding registers accept byte-wide accesses only.
// - legacy receive holding register at 0x000 + 0x200*n.
// - legacy write loads one tx byte, read unloads one rx byte.
module bfd_data_port #(
  parameter int NCHAN = 8,
  parameter int WF_DEPTH = 4
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic acc_valid,
  output logic acc_ready_r,
  input wire logic acc_write,
  input wire logic [11:0] acc_addr,
  input wire logic [3:0] acc_be,
  input wire logic [31:0] acc_wdata,
  output logic acc_done_r,
  output logic acc_err_r,
  output logic [31:0] acc_rdata_r,
  input wire logic [NCHAN-1:0] rx_have,
  input wire logic [8*NCHAN-1:0] rx_head_data,
  input wire logic [8*NCHAN-1:0] rx_head_status,
  output logic [NCHAN-1:0] rx_pop_r,
  output logic tx_valid_r,
  input wire logic tx_ready,
  output logic [2:0] tx_chan_r,
  output logic [7:0] tx_byte_r
);
  localparam int WFW = 3 + 4 + 32;

  // the channel field is three bits wide, so more channels cannot be served
  if (NCHAN < 1 || NCHAN > 8)
  begin : g_bad_nchan
    $error("channel count must lie between 1 and 8");
  end
  if (WF_DEPTH < 2)
  begin : g_bad_depth
    $error("write fifo needs at least two words");
  end

  bfd_pkg::bfd_win_t win;
  bfd_pkg::bfd_win_t rd_win_r, rd_win_nxt;
  bfd_pkg::bfd_rd_state_t rd_state_r, rd_state_nxt;
  logic [2:0] chan;
  logic [8:0] off;
  logic legal, take;
  logic [1:0] rd_idx_r, rd_idx_nxt;
  logic [3:0] rd_be_r, rd_be_nxt;
  logic [2:0] rd_chan_r, rd_chan_nxt;
  logic [31:0] rd_buf_r, rd_buf_nxt;
  logic [31:0] acc_rdata_nxt;
  logic acc_done_nxt, acc_err_nxt, acc_ready_nxt;
  logic [NCHAN-1:0] rx_pop_nxt;
  logic unit_on, adv;
  logic wf_in_valid, wf_in_ready, wf_out_valid, wf_out_ready;
  logic [WFW-1:0] wf_out_data;
  logic [3:0] tw_be_r, tw_be_nxt;
  logic [31:0] tw_data_r, tw_data_nxt;
  logic [2:0] tw_chan_r, tw_chan_nxt;
  logic tx_valid_nxt;
  logic [2:0] tx_chan_nxt;
  logic [7:0] tx_byte_nxt;

  // window decode; addresses outside every window are answered with an error
  assign chan = acc_addr[11:9];
  assign off = acc_addr[8:0];
  always_comb
  begin
    win = bfd_pkg::WIN_NONE;
    legal = 1'b0;
    if (32'(chan) < NCHAN)
    begin
      if (off[8:2] == 7'(`BFD_LEGACY_OFF >> 2))
      begin
        win = bfd_pkg::WIN_LEGACY;
        legal = (acc_be == `BFD_BE_LEGACY);
      end
      else if (off >= `BFD_DATA_OFF && off <= `BFD_DATA_END)
      begin
        win = bfd_pkg::WIN_DATA;
        legal = (acc_be != 4'h0);
      end
      else if (off >= `BFD_STAT_OFF && off <= `BFD_STAT_END)
      begin
        win = bfd_pkg::WIN_STAT;
        // a lone status or data byte would split a pair
        legal = !acc_write && (acc_be == `BFD_BE_LOW_HALF ||
          acc_be == `BFD_BE_HIGH_HALF || acc_be == `BFD_BE_FULL);
      end
    end
  end

  assign take = acc_valid && acc_ready_r;
  // writes go straight into the word fifo; ready guarantees room
  assign wf_in_valid = take && acc_write && legal;

  bfd_word_fifo #(
    .WIDTH(WFW),
    .DEPTH(WF_DEPTH)
  ) u_wfifo (
    .clock(clock),
    .resetn(resetn),
    .in_valid(wf_in_valid),
    .in_ready(wf_in_ready),
    .in_data({chan, acc_be, acc_wdata}),
    .out_valid(wf_out_valid),
    .out_ready(wf_out_ready),
    .out_data(wf_out_data)
  );

  // read sequencer: one lane or status pair per take/wait round
  always_comb
  begin
    rd_state_nxt = rd_state_r;
    rd_win_nxt = rd_win_r;
    rd_idx_nxt = rd_idx_r;
    rd_be_nxt = rd_be_r;
    rd_chan_nxt = rd_chan_r;
    rd_buf_nxt = rd_buf_r;
    acc_rdata_nxt = acc_rdata_r;
    acc_done_nxt = 1'b0;
    acc_err_nxt = 1'b0;
    rx_pop_nxt = '0;
    adv = 1'b0;
    if (rd_win_r == bfd_pkg::WIN_STAT)
      unit_on = !rd_idx_r[0] && (rd_be_r[rd_idx_r] || rd_be_r[rd_idx_r + 1'b1]);
    else
      unit_on = rd_be_r[rd_idx_r];
    unique case (rd_state_r)
      bfd_pkg::RD_IDLE:
      begin
        if (take)
        begin
          if (!legal || acc_write)
          begin
            acc_done_nxt = 1'b1;
            acc_err_nxt = !legal;
          end
          else
          begin
            rd_win_nxt = win;
            rd_be_nxt = acc_be;
            rd_chan_nxt = chan;
            rd_idx_nxt = 2'b00;
            rd_buf_nxt = {4{`BFD_EMPTY_BYTE}}; // empty fifo reads as zero
            rd_state_nxt = bfd_pkg::RD_TAKE;
          end
        end
      end
      bfd_pkg::RD_TAKE:
      begin
        if (unit_on && rx_have[rd_chan_r])
        begin
          if (rd_win_r == bfd_pkg::WIN_STAT)
          begin
            rd_buf_nxt[{rd_idx_r, 3'b000} +: 8] =
              rx_head_status[{rd_chan_r, 3'b000} +: 8];
            rd_buf_nxt[{rd_idx_r + 1'b1, 3'b000} +: 8] =
              rx_head_data[{rd_chan_r, 3'b000} +: 8];
          end
          else
            rd_buf_nxt[{rd_idx_r, 3'b000} +: 8] =
              rx_head_data[{rd_chan_r, 3'b000} +: 8];
          rx_pop_nxt[rd_chan_r] = 1'b1;
          rd_state_nxt = bfd_pkg::RD_WAIT;
        end
        else
          adv = 1'b1;
      end
      bfd_pkg::RD_WAIT:
        adv = 1'b1; // pop is on the pins now; head moves after this edge
      default:
        rd_state_nxt = bfd_pkg::RD_IDLE;
    endcase
    // lanes walk upward so the oldest byte lands lowest
    if (adv)
    begin
      if (rd_idx_r == 2'b11)
      begin
        acc_done_nxt = 1'b1;
        acc_rdata_nxt = rd_buf_nxt;
        rd_state_nxt = bfd_pkg::RD_IDLE;
      end
      else
      begin
        rd_idx_nxt = rd_idx_r + 1'b1;
        rd_state_nxt = bfd_pkg::RD_TAKE;
      end
    end
    // one idle cycle after each take lets the fifo count settle
    acc_ready_nxt = (rd_state_nxt == bfd_pkg::RD_IDLE) && !take &&
      wf_in_ready;
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      rd_state_r <= bfd_pkg::RD_IDLE;
      rd_win_r <= bfd_pkg::WIN_NONE;
      rd_idx_r <= 2'b00;
      rd_be_r <= 4'h0;
      rd_chan_r <= 3'h0;
      rd_buf_r <= 32'h0000_0000;
      acc_rdata_r <= 32'h0000_0000;
      acc_done_r <= 1'b0;
      acc_err_r <= 1'b0;
      acc_ready_r <= 1'b0;
      rx_pop_r <= '0;
    end
    else
    begin
      rd_state_r <= rd_state_nxt;
      rd_win_r <= rd_win_nxt;
      rd_idx_r <= rd_idx_nxt;
      rd_be_r <= rd_be_nxt;
      rd_chan_r <= rd_chan_nxt;
      rd_buf_r <= rd_buf_nxt;
      acc_rdata_r <= acc_rdata_nxt;
      acc_done_r <= acc_done_nxt;
      acc_err_r <= acc_err_nxt;
      acc_ready_r <= acc_ready_nxt;
      rx_pop_r <= rx_pop_nxt;
    end
  end

  // tx unpacker: a word is taken only when the last one is used up
  assign wf_out_ready = (tw_be_r == 4'h0);
  always_comb
  begin
    logic [1:0] sel;
    sel = 2'b00;
    tw_be_nxt = tw_be_r;
    tw_data_nxt = tw_data_r;
    tw_chan_nxt = tw_chan_r;
    tx_valid_nxt = tx_valid_r && !tx_ready;
    tx_chan_nxt = tx_chan_r;
    tx_byte_nxt = tx_byte_r;
    for (int i = 3; i >= 0; i--)
      if (tw_be_r[i])
        sel = 2'(i); // lowest enabled lane wins
    if (wf_out_valid && wf_out_ready)
    begin
      tw_chan_nxt = wf_out_data[WFW-1 -: 3];
      tw_be_nxt = wf_out_data[35:32];
      tw_data_nxt = wf_out_data[31:0];
    end
    else if (tw_be_r != 4'h0 && (!tx_valid_r || tx_ready))
    begin
      tx_valid_nxt = 1'b1;
      tx_chan_nxt = tw_chan_r;
      tx_byte_nxt = tw_data_r[{sel, 3'b000} +: 8];
      tw_be_nxt[sel] = 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      tw_be_r <= 4'h0;
      tw_data_r <= 32'h0000_0000;
      tw_chan_r <= 3'h0;
      tx_valid_r <= 1'b0;
      tx_chan_r <= 3'h0;
      tx_byte_r <= 8'h00;
    end
    else
    begin
      tw_be_r <= tw_be_nxt;
      tw_data_r <= tw_data_nxt;
      tw_chan_r <= tw_chan_nxt;
      tx_valid_r <= tx_valid_nxt;
      tx_chan_r <= tx_chan_nxt;
      tx_byte_r <= tx_byte_nxt;
    end
  end
endmodule : bfd_data_port

// >>> verif/bfd_chk.sv
// port checker for the burst data port
`timescale 1ns/10ps
module bfd_chk #(
  parameter int NCHAN = 8
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic acc_valid,
  input wire logic acc_ready_r,
  input wire logic acc_write,
  input wire logic [11:0] acc_addr,
  input wire logic [3:0] acc_be,
  input wire logic acc_done_r,
  input wire logic acc_err_r,
  input wire logic [NCHAN-1:0] rx_have,
  input wire logic [NCHAN-1:0] rx_pop_r,
  input wire logic tx_valid_r,
  input wire logic tx_ready,
  input wire logic [2:0] tx_chan_r,
  input wire logic [7:0] tx_byte_r
);
  logic tk;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // a request is taken at an edge with valid and ready
  assign tk = acc_valid && acc_ready_r;
  // access port handshake and answer timing
  rdy_drop_a: assert property (tk |=> !acc_ready_r)
    else $error("ready held after take");
  wr_done_a: assert property (tk && acc_write |=> acc_done_r)
    else $error("write not answered");
  rd_done_a: assert property (tk && !acc_write |-> ##[1:9] acc_done_r)
    else $error("read not answered in time");
  err_done_a: assert property (acc_err_r |-> acc_done_r)
    else $error("error without done");
  done_once_a: assert property (acc_done_r |=> !acc_done_r)
    else $error("done longer than a cycle");
  // pops: one channel at a time, only with a valid head, never on writes
  pop_one_a: assert property ($onehot0(rx_pop_r))
    else $error("several channels popped");
  pop_have_a: assert property ((rx_pop_r & ~$past(rx_have)) == '0)
    else $error("pop of an empty fifo");
  wr_nopop_a: assert property (tk && acc_write |=> (rx_pop_r == '0)[*2])
    else $error("write popped rx");
  // tx byte stands until taken
  tx_hold_a: assert property (tx_valid_r && !tx_ready |=> tx_valid_r
    && $stable(tx_byte_r) && $stable(tx_chan_r))
    else $error("tx byte changed while stalled");
  // refusals of status writes and wide legacy accesses
  st_wr_a: assert property (tk && acc_write && acc_addr[8:7] == 2'h3
    |=> acc_err_r)
    else $error("status write accepted");
  leg_be_a: assert property (tk && acc_addr[8:0] == 9'h000
    && acc_be != 4'h1 |=> acc_err_r)
    else $error("wide legacy access accepted");
  c_pop: cover property (|rx_pop_r);
  c_err: cover property (acc_err_r);
  c_tx: cover property (tx_valid_r && tx_ready);
endmodule : bfd_chk

// >>> verif/bfd_chan_model.sv
// model of the channel fifos behind the data port
`timescale 1ns/10ps
module bfd_chan_model #(
  parameter int NCHAN = 8,
  parameter int FILL = 8
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [NCHAN-1:0] rx_pop_r,
  output logic [NCHAN-1:0] rx_have,
  output logic [8*NCHAN-1:0] rx_head_data,
  output logic [8*NCHAN-1:0] rx_head_status,
  output logic tx_ready
);
  logic [7:0] cnt [NCHAN] = '{default: 8'h0};
  logic [7:0] d, s;
  // empty fifo shows the inverse so a stale byte cannot pass
  always_comb
  begin
    for (int n = 0; n < NCHAN; n++)
    begin
      d = {3'(n), cnt[n][4:0]};
      s = {cnt[n][4:0], 3'(n)};
      rx_have[n] = cnt[n] < 8'(FILL);
      rx_head_data[8*n+:8] = rx_have[n] ? d : ~d;
      rx_head_status[8*n+:8] = rx_have[n] ? s : ~s;
    end
  end
  // head moves on, fifo refilled only by reset
  always @(posedge clock)
    for (int n = 0; n < NCHAN; n++)
      cnt[n] <= !resetn ? 8'h0 : cnt[n] + 8'(rx_pop_r[n]);
  // tx fifo stalls about one cycle in four
  always @(negedge clock)
    tx_ready <= resetn && ($urandom % 4 != 0);
endmodule : bfd_chan_model

// >>> verif/bfd_data_port_tb_top.sv
// self-checking bench for the burst data port
`timescale 1ns/10ps
module bfd_data_port_tb_top;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic acc_valid = 1'b0;
  logic acc_write = 1'b0;
  logic [11:0] acc_addr = 12'h0;
  logic [3:0] acc_be = 4'h0;
  logic [31:0] acc_wdata = 32'h0;
  logic acc_ready_r, acc_done_r, acc_err_r, tx_valid_r, tx_ready;
  logic [31:0] acc_rdata_r;
  logic [7:0] rx_have, rx_pop_r, tx_byte_r;
  logic [63:0] rx_head_data, rx_head_status;
  logic [2:0] tx_chan_r;
  logic [7:0] tcnt [8] = '{default: 8'h0};
  logic [65:0] rq [$];
  logic [10:0] tq [$];
  logic [65:0] nt;
  int failures = 0;
  int total_checks = 0;
  int i, ch;
  initial forever #12.5 clock = ~clock;
  bfd_data_port dut (.clock(clock), .resetn(resetn), .acc_valid(acc_valid),
    .acc_ready_r(acc_ready_r), .acc_write(acc_write), .acc_addr(acc_addr),
    .acc_be(acc_be), .acc_wdata(acc_wdata), .acc_done_r(acc_done_r),
    .acc_err_r(acc_err_r), .acc_rdata_r(acc_rdata_r), .rx_have(rx_have),
    .rx_head_data(rx_head_data), .rx_head_status(rx_head_status),
    .rx_pop_r(rx_pop_r), .tx_valid_r(tx_valid_r), .tx_ready(tx_ready),
    .tx_chan_r(tx_chan_r), .tx_byte_r(tx_byte_r));
  bfd_chan_model pm (.clock(clock), .resetn(resetn), .rx_pop_r(rx_pop_r),
    .rx_have(rx_have), .rx_head_data(rx_head_data),
    .rx_head_status(rx_head_status), .tx_ready(tx_ready));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  task bound(input logic t);
    if (t)
    begin
      failures++;
      $display("MISMATCH at %0t: wait ran out", $time);
      end_sim();
    end
  endtask : bound
  // next rx head of a channel as {data, status}, zero once empty
  function automatic logic [15:0] nxt(input int c);
    logic [7:0] n;
    n = tcnt[c];
    if (n >= 8'h8)
      return 16'h0;
    tcnt[c] = n + 8'h1;
    return {3'(c), n[4:0], n[4:0], 3'(c)};
  endfunction : nxt
  // one access, held until taken, then wait for its answer
  task acc(input logic w, input logic [11:0] a, input logic [3:0] be,
    input logic [31:0] wd, input logic [65:0] n);
    int j;
    rq.push_back(n);
    @(negedge clock);
    acc_valid = 1'b1;
    acc_write = w;
    acc_addr = a;
    acc_be = be;
    acc_wdata = wd;
    for (j = 0; j < 400 && !acc_ready_r; j++)
      @(negedge clock);
    bound(j == 400);
    @(negedge clock);
    acc_valid = 1'b0;
    for (j = 0; j < 400 && rq.size() > 0; j++)
      @(negedge clock);
    bound(j == 400);
  endtask : acc
  task wr(input int c, input logic [8:0] o, input logic [3:0] be,
    input logic [31:0] wd, input logic e);
    for (int k = 0; k < 4; k++)
      if (be[k] && !e)
        tq.push_back({3'(c), wd[8*k+:8]});
    acc(1'b1, {3'(c), o}, be, wd, {1'b0, e, 64'h0});
  endtask : wr
  task rd(input int c, input logic [8:0] o, input logic [3:0] be);
    logic [31:0] d;
    logic [15:0] h;
    d = 32'h0;
    for (int k = 0; k < 4; k++)
      if (be[k] && !(o[7] && k[0]))
      begin
        h = nxt(c);
        if (o[7])
          d[8*k+:16] = h;
        else
          d[8*k+:8] = h[15:8];
      end
    acc(1'b0, {3'(c), o}, be, 32'h0,
      {2'h2, {8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}, d});
  endtask : rd
  // answers and tx bytes against the oldest note
  always @(posedge clock)
    if (resetn)
    begin
      if (acc_done_r)
      begin
        check(32'(rq.size()), 32'h1);
        nt = rq.pop_front();
        check({31'h0, acc_err_r}, {31'h0, nt[64]});
        if (nt[65])
          check(acc_rdata_r & nt[63:32], nt[31:0]);
      end
      if (tx_valid_r && tx_ready)
      begin
        check(32'(tq.size() > 0), 32'h1);
        check({21'h0, tx_chan_r, tx_byte_r}, {21'h0, tq.pop_front()});
      end
    end
  initial
  begin
    i = $urandom(74);
    repeat (4) @(negedge clock);
    resetn = 1'b1;
    // refused accesses move nothing; the drain below proves no pop
    wr(0, 9'h100, 4'h0, 32'h0, 1'b1);
    wr(1, 9'h180, 4'hf, 32'h0, 1'b1);
    wr(2, 9'h000, 4'h3, 32'h0, 1'b1);
    acc(1'b0, 12'h004, 4'hf, 32'h0, {2'h1, 64'h0});
    acc(1'b0, 12'h340, 4'hf, 32'h0, {2'h1, 64'h0});
    acc(1'b0, 12'h580, 4'h1, 32'h0, {2'h1, 64'h0});
    acc(1'b0, 12'h600, 4'hf, 32'h0, {2'h1, 64'h0});
    $display("test refusals done");
    // drain each channel through all views, ending on empty lanes
    for (ch = 0; ch < 8; ch++)
    begin
      rd(ch, 9'h180, 4'hf);
      rd(ch, 9'h1fc, 4'h3);
      rd(ch, 9'h184, 4'hc);
      rd(ch, 9'h000, 4'h1);
      rd(ch, 9'h13c, 4'hf);
      rd(ch, 9'h100, 4'hf);
    end
    $display("test rx drain done");
    // random words fill the word fifo while the tx side stalls
    for (i = 0; i < 48; i++)
    begin
      ch = $urandom % 8;
      if (i % 6 == 0)
        wr(ch, 9'h000, 4'h1, $urandom, 1'b0);
      else
        wr(ch, 9'h100 + 9'(4 * (i % 16)), 4'($urandom % 15 + 1),
          $urandom, 1'b0);
    end
    for (i = 0; i < 4000 && tq.size() > 0; i++)
      @(negedge clock);
    bound(tq.size() > 0);
    $display("test tx writes done");
    end_sim();
  end
endmodule : bfd_data_port_tb_top
bind bfd_data_port bfd_chk #(.NCHAN(NCHAN)) chk (.clock(clock),
  .resetn(resetn), .acc_valid(acc_valid), .acc_ready_r(acc_ready_r),
  .acc_write(acc_write), .acc_addr(acc_addr), .acc_be(acc_be),
  .acc_done_r(acc_done_r), .acc_err_r(acc_err_r), .rx_have(rx_have),
  .rx_pop_r(rx_pop_r), .tx_valid_r(tx_valid_r), .tx_ready(tx_ready),
  .tx_chan_r(tx_chan_r), .tx_byte_r(tx_byte_r));
